// ==== hw/tone_pkg.sv ====
// Shared constants, register map and mode types of the copier tone pipeline.
package tone_pkg;
   typedef enum {TEXT1, TEXT2, PHOTO1, PHOTO2, PHOTO3,
      SPEC1, SPEC2, SPEC3, SPEC4, SPEC5} orig_mode_t;
   typedef enum {LW_DEFAULT, LW_OFF, LW_THIN, LW_THICK} line_width_t;
   localparam logic [11:0] MODE_ADDR = 12'h000;
   localparam logic [11:0] TUNE_ADDR = 12'h004;
   localparam logic [11:0] COUNT_ADDR = 12'h008;
   localparam int MODE_LSB = 0;
   localparam int DENS_LSB = 4;
   localparam int LOWSTR_LSB = 0;
   localparam int DOTLVL_LSB = 4;
   localparam int LW_LSB = 8;
   localparam int TEX_LSB = 12;
   localparam int GADJ_LSB = 16;
   localparam int DSEL_LSB = 20;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [2:0] DENS_RESET = 3'h3;
   localparam logic [2:0] LOWSTR_RESET = 3'h0;
   localparam logic [2:0] DOTLVL_RESET = 3'h2;
   localparam logic [2:0] TEX_DEFAULT_ON = 3'h3;
   localparam logic [2:0] TEX_NONE = 3'h1;
   localparam int TEX_MAX = 6;
   localparam int BIN_TH = 128;
   localparam int ED_TH = 128;
   localparam int EDGE_TH = 48;
   localparam int LOW_MIN = 16;
   localparam int LOW_MAX = 96;
   localparam int DOT_NB_BASE = 16;
   localparam int DOT_STEP = 16;
   localparam int DENS_STEP = 12;
   localparam int GADJ_STEP = 6;
   localparam int PHOTO_WHITE = 240;
   localparam int PULSE_FULL = 3;
   localparam int PULSE_3Q = 2;
   localparam int PULSE_HALF = 1;
   localparam logic [1:0] POS_LEFT = 2'h0;
   localparam logic [1:0] POS_CENTRE = 2'h1;
   localparam logic [1:0] POS_RIGHT = 2'h2;
endpackage

// ==== hw/pix_win_if.sv ====
// Carrier of the 3x3 pixel window and its position between the line store and the filter.
`timescale 1ns/1ns
`default_nettype none
interface pix_win_if;
   logic [8:0][7:0] win;
   logic valid;
   logic [2:0] col;
   logic [2:0] row;
   logic lineHead;
   modport src(output win, valid, col, row, lineHead);
   modport dst(input win, valid, col, row, lineHead);
endinterface
`default_nettype wire

// ==== hw/line_window.sv ====
// Two-line store that presents a 3x3 window of the incoming pixel stream.
`timescale 1ns/1ns
`default_nettype none
module line_window #(
   parameter int LINE_W = 2048
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic pixValid,
   input wire logic [7:0] pixData,
   input wire logic lineEnd,
   input wire logic pageStart,
   pix_win_if.src w
);
   localparam int AW = $clog2(LINE_W);
   if (LINE_W < 8) begin : g_bad
      $error("line_window: LINE_W must be at least 8");
   end
   logic [7:0] lineOld [LINE_W];
   logic [7:0] lineMid [LINE_W];
   logic [AW-1:0] col;
   logic [2:0] row;
   logic [2:0][7:0] topSh, midSh, botSh;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         col <= '0;
         row <= '0;
      end else if (pixValid) begin
         if (lineEnd || col == AW'(LINE_W - 1)) begin
            col <= '0;
            row <= pageStart ? 3'h1 : row + 3'h1;
         end else begin
            col <= col + 1'b1;
            if (pageStart) begin
               row <= '0;
            end
         end
      end
   end

   // The stores carry no reset; stale data only affects the first two lines of a page.
   always_ff @(posedge clk) begin
      if (pixValid) begin
         lineMid[col] <= pixData;
         lineOld[col] <= lineMid[col];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         topSh <= '0;
         midSh <= '0;
         botSh <= '0;
         w.valid <= 1'b0;
         w.col <= '0;
         w.row <= '0;
         w.lineHead <= 1'b0;
      end else begin
         w.valid <= pixValid;
         if (pixValid) begin
            topSh <= {lineOld[col], topSh[2:1]};
            midSh <= {lineMid[col], midSh[2:1]};
            botSh <= {pixData, botSh[2:1]};
            w.col <= col[2:0];
            w.row <= row;
            w.lineHead <= (col == '0);
         end
      end
   end

   assign w.win = {botSh, midSh, topSh};
endmodule
`default_nettype wire

// ==== hw/threshold_tile.sv ====
// Four 8x8 threshold matrices (256 values) used for texture removal and dithering.
`timescale 1ns/1ns
`default_nettype none
module threshold_tile (
   input wire logic [7:0] texIdx,
   input wire logic [7:0] ditIdx,
   output logic [7:0] texTh,
   output logic [7:0] ditTh
);
   logic [7:0] thStore [256];

   // Index is {matrix, row, col}; each matrix is an ordered 8x8 pattern at its own contrast.
   function automatic logic [7:0] entry(input logic [7:0] i);
      logic [5:0] b;
      int d;
      b = {i[0] ^ i[3], i[3], i[1] ^ i[4], i[4], i[2] ^ i[5], i[5]};
      d = (int'(b) * 4 - 126) * (int'(i[7:6]) + 1) / 4;
      return 8'(128 + d);
   endfunction

   always_comb begin
      for (int k = 0; k < 256; k++) begin
         thStore[k] = entry(8'(k));
      end
   end

   assign texTh = thStore[texIdx];
   assign ditTh = thStore[ditIdx];
endmodule
`default_nettype wire

// ==== hw/copy_image_tone_pipeline.sv ====
// Copier pixel back end: filtering, density gamma, gradation, edge smoothing, printer gamma.
//
// Overview of operation
// R1: Sharpen runs of low-density pixels in listed modes.
// R2: Strength setting zero is per-mode base strength.
// R3: Erase isolated dots in listed modes.
// R4: Dot erase ignores density; level widens detection.
// R5: Line width correction; default off except Special 2.
// R6: Density gamma from mode, panel level, adjust.
// R7: Text 2, Special 1 binarise at fixed threshold.
// R8: Error diffusion in Text1, Photo1-3, Special 2, 5.
// R9: Texture removal ends error diffusion, per-mode defaults.
// R10: Texture thresholds: 256 values, tiled 8x8 matrix.
// R11: Setting 0 default, 1 off, 2-6 level.
// R12: Default level 3, or 1 for Photo 1, 3.
// R13: Dithering only in Special 3 and 4.
// R14: Binary edge smoothing: four widths, three positions.
// R15: Printer gamma chosen by original type.
// R16: Edge/solid classification by neighbours picks filter.
// R17: One pixel per clock, order kept, fixed latency.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module copy_image_tone_pipeline #(
   parameter int LINE_W = 2048
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pixValid,
   input wire logic [7:0] pixData,
   input wire logic lineEnd,
   input wire logic pageStart,
   output logic outValid,
   output logic [7:0] outPix,
   output logic outBit,
   output logic [1:0] pulseWidth,
   output logic [1:0] pulsePos
);
   import tone_pkg::*;

   logic [3:0] modeSel;
   logic [2:0] densLevel;
   logic [2:0] lowLineStrength;
   logic [2:0] dotEraseLevel;
   logic [1:0] lineWidthSetting;
   logic [2:0] textureRemovalLevel;
   logic [3:0] densityGammaAdjust;
   logic [1:0] ditherSel;
   logic [23:0] pixCount;
   orig_mode_t mode;

   function automatic orig_mode_t toMode(input logic [3:0] m);
      orig_mode_t r;
      r = TEXT1;
      for (int k = 0; k <= int'(SPEC5); k++) begin
         if (int'(m) == k) begin
            r = orig_mode_t'(k);
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] sat8(input int v);
      return (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : 8'(v);
   endfunction

   function automatic logic isPhoto(input orig_mode_t m);
      return m == PHOTO1 || m == PHOTO2 || m == PHOTO3;
   endfunction

   // Modes that use low-density sharpening, dot erase and line width correction.
   function automatic logic isFilterMode(input orig_mode_t m);
      return m == TEXT1 || m == TEXT2 || m == PHOTO2 ||
         m == SPEC1 || m == SPEC2 || m == SPEC5;
   endfunction

   function automatic logic isBinMode(input orig_mode_t m);
      return m == TEXT2 || m == SPEC1;
   endfunction

   function automatic logic isDitherMode(input orig_mode_t m);
      return m == SPEC3 || m == SPEC4;
   endfunction

   function automatic int modeBase(input orig_mode_t m);
      return isPhoto(m) ? 1 : (m == TEXT2) ? 3 : 2;
   endfunction

   assign mode = toMode(modeSel);

   // APB slave: zero wait states, unmapped addresses answer with pslverr and zero data.
   logic apbAcc;
   logic [11:0] regAddr;
   logic addrHit;
   assign apbAcc = psel & penable;
   assign regAddr = paddr[11:0];
   assign pready = 1'b1;

   always_comb begin
      addrHit = 1'b1;
      prdata = '0;
      if (paddr[31:12] != '0) begin
         addrHit = 1'b0;
      end else if (regAddr == MODE_ADDR) begin
         prdata[MODE_LSB +: 4] = modeSel;
         prdata[DENS_LSB +: 3] = densLevel;
      end else if (regAddr == TUNE_ADDR) begin
         prdata[LOWSTR_LSB +: 3] = lowLineStrength;
         prdata[DOTLVL_LSB +: 3] = dotEraseLevel;
         prdata[LW_LSB +: 2] = lineWidthSetting;
         prdata[TEX_LSB +: 3] = textureRemovalLevel;
         prdata[GADJ_LSB +: 4] = densityGammaAdjust;
         prdata[DSEL_LSB +: 2] = ditherSel;
      end else if (regAddr == COUNT_ADDR) begin
         prdata[23:0] = pixCount;
      end else begin
         addrHit = 1'b0;
      end
      if (!apbAcc || pwrite) begin
         prdata = '0;
      end
   end
   assign pslverr = apbAcc & ~addrHit;

   // Settings are taken as written; software keeps them steady across a page. [R17]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         modeSel <= MODE_RESET;
         densLevel <= DENS_RESET;
         lowLineStrength <= LOWSTR_RESET; // [R2]
         dotEraseLevel <= DOTLVL_RESET;
         lineWidthSetting <= 2'(LW_DEFAULT);
         textureRemovalLevel <= '0;
         densityGammaAdjust <= '0;
         ditherSel <= '0;
      end else if (apbAcc && pwrite && regAddr == MODE_ADDR && paddr[31:12] == '0) begin
         modeSel <= pwdata[MODE_LSB +: 4];
         densLevel <= pwdata[DENS_LSB +: 3];
      end else if (apbAcc && pwrite && regAddr == TUNE_ADDR && paddr[31:12] == '0) begin
         lowLineStrength <= pwdata[LOWSTR_LSB +: 3];
         dotEraseLevel <= pwdata[DOTLVL_LSB +: 3];
         lineWidthSetting <= pwdata[LW_LSB +: 2];
         textureRemovalLevel <= pwdata[TEX_LSB +: 3];
         densityGammaAdjust <= pwdata[GADJ_LSB +: 4];
         ditherSel <= pwdata[DSEL_LSB +: 2];
      end
   end

   pix_win_if w();

   line_window #(.LINE_W(LINE_W)) u_win (
      .clk(clk),
      .rst(rst),
      .pixValid(pixValid),
      .pixData(pixData),
      .lineEnd(lineEnd),
      .pageStart(pageStart),
      .w(w)
   );

   // Stage A: neighbourhood filters on the window centre.
   logic [7:0] cen;
   logic [7:0] nbMax, nbMin, winMax, winMin;
   int nbSum;
   logic edgePix, lowLine, isolated;
   int gain;
   logic [7:0] filtPix;
   line_width_t lwEff;

   always_comb begin
      cen = w.win[4];
      nbSum = 0;
      nbMax = 8'h00;
      nbMin = 8'hFF;
      for (int k = 0; k < 9; k++) begin
         if (k != 4) begin
            nbSum = nbSum + int'(w.win[k]);
            nbMax = (w.win[k] > nbMax) ? w.win[k] : nbMax;
            nbMin = (w.win[k] < nbMin) ? w.win[k] : nbMin;
         end
      end
      winMax = (cen > nbMax) ? cen : nbMax;
      winMin = (cen < nbMin) ? cen : nbMin;
      edgePix = (int'(winMax) - int'(winMin)) > EDGE_TH; // [R16]
      lowLine = 1'b1;
      for (int k = 3; k < 6; k++) begin
         if (int'(w.win[k]) < LOW_MIN || int'(w.win[k]) > LOW_MAX) begin
            lowLine = 1'b0;
         end
      end
      // The centre need only be darker than every neighbour; a higher level admits darker surroundings. [R4]
      isolated = int'(nbMax) <= DOT_NB_BASE + int'(dotEraseLevel) * DOT_STEP && cen > nbMax;
      gain = 0;
      if (lowLine && isFilterMode(mode)) begin
         gain = modeBase(mode) + int'(lowLineStrength); // [R1] [R2]
      end else if (edgePix && mode != SPEC3 && mode != SPEC4) begin
         gain = modeBase(mode); // [R16]
      end else if (!edgePix && mode == TEXT2) begin
         gain = modeBase(mode) - 1; // [R16]
      end
      filtPix = sat8(int'(cen) + ((int'(cen) - nbSum / 8) * gain) / 4);
      lwEff = line_width_t'(lineWidthSetting);
      if (lwEff == LW_DEFAULT) begin
         lwEff = (mode == SPEC2) ? LW_THICK : LW_OFF; // [R5]
      end
      if (isFilterMode(mode) && lwEff == LW_THICK) begin
         filtPix = (w.win[3] > filtPix) ? w.win[3] : filtPix; // [R5]
         filtPix = (w.win[5] > filtPix) ? w.win[5] : filtPix;
      end else if (isFilterMode(mode) && lwEff == LW_THIN) begin
         filtPix = (w.win[3] < filtPix) ? w.win[3] : filtPix; // [R5]
         filtPix = (w.win[5] < filtPix) ? w.win[5] : filtPix;
      end
      if (isFilterMode(mode) && isolated) begin
         filtPix = 8'h00; // [R3]
      end
   end

   logic aValid, aHead, aLeftBlk, aRightBlk;
   logic [7:0] aPix;
   logic [2:0] aCol, aRow;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aValid <= 1'b0;
         aPix <= '0;
         aCol <= '0;
         aRow <= '0;
         aHead <= 1'b0;
         aLeftBlk <= 1'b0;
         aRightBlk <= 1'b0;
      end else begin
         aValid <= w.valid; // [R17]
         if (w.valid) begin
            aPix <= filtPix;
            aCol <= w.col;
            aRow <= w.row;
            aHead <= w.lineHead;
            aLeftBlk <= int'(w.win[3]) >= BIN_TH;
            aRightBlk <= int'(w.win[5]) >= BIN_TH;
         end
      end
   end

   // Stage B: density gamma, gradation, edge smoothing and printer gamma.
   logic [7:0] texTh, ditTh;
   logic [2:0] texEff;
   logic [7:0] gamPix;
   int errAcc, corr, th;
   logic dotOn;
   logic [1:0] nextWidth, nextPos;
   logic [7:0] nextPix;

   threshold_tile u_tile (
      .texIdx({2'h3, aRow, aCol}), // [R10]
      .ditIdx({ditherSel, aRow, aCol}),
      .texTh(texTh),
      .ditTh(ditTh)
   );

   always_comb begin
      texEff = textureRemovalLevel; // [R11]
      if (int'(texEff) > TEX_MAX) begin
         texEff = 3'(TEX_MAX);
      end
      if (texEff == '0) begin
         texEff = (mode == PHOTO1 || mode == PHOTO3) ? TEX_NONE : TEX_DEFAULT_ON; // [R12]
      end
      gamPix = sat8(int'(aPix) + (int'(densLevel) - int'(DENS_RESET)) * DENS_STEP
         + int'($signed(densityGammaAdjust)) * GADJ_STEP
         + (isPhoto(mode) ? (int'(aPix) * (255 - int'(aPix))) / 512 : 0)); // [R6]
      corr = int'(gamPix) + (aHead ? 0 : errAcc);
      th = ED_TH;
      if (texEff != TEX_NONE) begin
         th = 128 + ((int'(texTh) - 128) * (int'(texEff) - 1)) / (TEX_MAX - 1); // [R9]
      end
      if (isBinMode(mode)) begin
         dotOn = int'(gamPix) >= BIN_TH; // [R7]
      end else if (isDitherMode(mode)) begin
         dotOn = gamPix >= ditTh; // [R13]
      end else begin
         dotOn = corr >= th; // [R8]
      end
      nextWidth = 2'(PULSE_FULL);
      nextPos = POS_CENTRE;
      if (isBinMode(mode) && dotOn) begin
         if (!aLeftBlk && !aRightBlk) begin
            nextWidth = 2'(PULSE_HALF); // [R14]
         end else if (!aLeftBlk) begin
            nextWidth = 2'(PULSE_3Q); // [R14]
            nextPos = POS_RIGHT;
         end else if (!aRightBlk) begin
            nextWidth = 2'(PULSE_3Q);
            nextPos = POS_LEFT;
         end
      end
      nextPix = dotOn ? (isPhoto(mode) ? 8'(PHOTO_WHITE) : 8'hFF) : 8'h00; // [R15]
   end

   // Error carried to the next pixel on the same line; not added at each line head, where corr ignores errAcc. [R8]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         errAcc <= 0;
      end else if (aValid) begin
         errAcc <= (isBinMode(mode) || isDitherMode(mode)) ? 0 : corr - (dotOn ? 255 : 0);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         outValid <= 1'b0;
         outPix <= '0;
         outBit <= 1'b0;
         pulseWidth <= '0;
         pulsePos <= POS_CENTRE;
      end else begin
         outValid <= aValid; // [R17]
         if (aValid) begin
            outPix <= nextPix;
            outBit <= dotOn;
            pulseWidth <= dotOn ? nextWidth : 2'h0;
            pulsePos <= nextPos;
         end
      end
   end

   // Output pixels since the last page start.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pixCount <= '0;
      end else if (pixValid && pageStart) begin
         pixCount <= '0;
      end else if (outValid) begin
         pixCount <= pixCount + 24'h00_0001;
      end
   end
endmodule
`default_nettype wire

// ==== bench/copy_image_tone_pipeline_assertions.sv ====
// Port-level checks of the copier tone pipeline, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module copy_image_tone_pipeline_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pixValid,
   input wire logic outValid,
   input wire logic [7:0] outPix,
   input wire logic [1:0] pulsePos
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_ready_high: assert property (pready)
      else $error("pready low");
   chk_err_unmapped: assert property (psel && penable && paddr[31:12] != 20'h0_0000 |-> pslverr)
      else $error("no error on unmapped access");
   chk_err_mapped: assert property (psel && penable && paddr inside {32'h0000_0000, 32'h0000_0004} |-> !pslverr)
      else $error("error on mapped access");
   chk_rdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0000_0000)
      else $error("read data outside access phase");
   chk_out_latency: assert property (pixValid |-> ##3 outValid)
      else $error("output pixel missing");
   chk_out_cause: assert property (outValid |-> $past(pixValid, 3))
      else $error("output pixel without input");
   chk_pix_levels: assert property (outValid |-> outPix inside {8'h00, 8'hFF, 8'hF0})
      else $error("output level outside gamma set");
   chk_pos_legal: assert property (outValid |-> pulsePos != 2'h3)
      else $error("pulse position outside three");
endmodule
bind copy_image_tone_pipeline copy_image_tone_pipeline_assertions chk (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pixValid(pixValid), .outValid(outValid), .outPix(outPix), .pulsePos(pulsePos));
`default_nettype wire

// ==== bench/scanner_source.sv ====
// Scanner front end model: streams one page of pixels, one per clock when valid.
`timescale 1ns/1ns
`default_nettype none
module scanner_source (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [7:0] level,
   input wire logic rnd,
   input wire logic gaps,
   input var int dotIdx,
   input var int lineLen,
   input var int numLines,
   output logic pixValid,
   output logic [7:0] pixData,
   output logic lineEnd,
   output logic pageStart,
   output logic busy
);
   int idx;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         idx <= 0;
         busy <= 1'b0;
         pixValid <= 1'b0;
         pixData <= 8'h00;
         lineEnd <= 1'b0;
         pageStart <= 1'b0;
      end else if (start && !busy) begin
         busy <= 1'b1;
         idx <= 0;
      end else if (busy && idx < lineLen * numLines && !(gaps && $urandom_range(0, 3) == 0)) begin
         pixValid <= 1'b1;
         pixData <= rnd ? 8'($urandom) : (idx == dotIdx ? 8'hFF : level);
         lineEnd <= (idx % lineLen) == lineLen - 1;
         pageStart <= idx == 0;
         idx <= idx + 1;
      end else begin
         // Idle data flips so a stale pixel can never be mistaken for a fresh one.
         pixValid <= 1'b0;
         pixData <= ~pixData;
         lineEnd <= 1'b0;
         pageStart <= 1'b0;
         if (busy && idx >= lineLen * numLines) begin
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== bench/copy_image_tone_pipeline_bench.sv ====
// Self-checking bench of the copier tone pipeline: registers, gradation modes, dot erase, counts.
`timescale 1ns/1ns
`default_nettype none
module copy_image_tone_pipeline_bench;
   import tone_pkg::*;
   localparam int LW = 16;
   localparam int NL = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, pixValid, lineEnd, pageStart, outValid, outBit, busy;
   logic [7:0] pixData, outPix;
   logic [1:0] pulseWidth, pulsePos;
   logic start = 1'b0;
   logic rnd = 1'b0;
   logic gaps = 1'b0;
   logic [7:0] level = 8'h00;
   int dotIdx = -1;
   int num_errors = 0;
   int checked = 0;
   int outIdx, inner, ones, fulls;
   int curMode = 0;
   always #20 clk = ~clk;
   copy_image_tone_pipeline #(.LINE_W(LW)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pixValid(pixValid), .pixData(pixData), .lineEnd(lineEnd), .pageStart(pageStart), .outValid(outValid),
      .outPix(outPix), .outBit(outBit), .pulseWidth(pulseWidth), .pulsePos(pulsePos));
   scanner_source src (.clk(clk), .rst(rst), .start(start), .level(level), .rnd(rnd), .gaps(gaps),
      .dotIdx(dotIdx), .lineLen(LW), .numLines(NL), .pixValid(pixValid), .pixData(pixData),
      .lineEnd(lineEnd), .pageStart(pageStart), .busy(busy));
   // Only pixels whose whole window lies inside the page are counted, so border handling stays free.
   always @(posedge clk) begin
      if (outValid === 1'b1) begin
         check("outPix level", print_level(curMode, outBit), outPix);
         if (outBit !== 1'b1) begin
            check("pulse without dot", 0, pulseWidth);
         end
         if (outIdx / LW >= 3 && outIdx % LW >= 3 && outIdx % LW <= LW - 2) begin
            inner++;
            ones += (outBit === 1'b1);
            fulls += (outBit === 1'b1 && pulseWidth === 2'(PULSE_FULL));
         end
         outIdx++;
      end
   end
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(logic wr, logic [31:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic grey_mixed(int m);
      return !(m == TEXT2 || m == SPEC1);
   endfunction
   function automatic logic [31:0] print_level(int m, logic b);
      if (b !== 1'b1) begin
         return 32'h0000_0000;
      end
      return (m == PHOTO1 || m == PHOTO2 || m == PHOTO3) ? 32'(PHOTO_WHITE) : 32'h0000_00FF;
   endfunction
   task automatic page(int m, logic [7:0] lv, int dot, logic r);
      logic [31:0] q;
      logic e;
      apb(1'b1, 32'(MODE_ADDR), 32'(m) | (32'(DENS_RESET) << DENS_LSB), q, e);
      level <= lv;
      dotIdx <= dot;
      rnd <= r;
      gaps <= r;
      curMode = m;
      outIdx = 0;
      inner = 0;
      ones = 0;
      fulls = 0;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
      repeat (6) @(posedge clk);
      apb(1'b0, 32'(COUNT_ADDR), 32'h0000_0000, q, e);
      check("pixel count", LW * NL, q);
   endtask
   task automatic complete_run;
      if (num_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #(40 * 20000);
      num_errors++;
      complete_run();
   end
   initial begin
      logic [31:0] q, v;
      logic e;
      void'($urandom(43));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("outValid reset", 0, outValid);
      check("pulsePos reset", 1, pulsePos);
      apb(1'b0, 32'(MODE_ADDR), 0, q, e);
      check("MODE reset", 32'(DENS_RESET) << DENS_LSB, q);
      apb(1'b0, 32'(TUNE_ADDR), 0, q, e);
      check("TUNE reset", 32'(DOTLVL_RESET) << DOTLVL_LSB, q);
      for (int i = 0; i < 6; i++) begin
         v = $urandom & 32'h003F_7377;
         if (v[14:12] == 3'h7) v[14:12] = 3'h6;
         apb(1'b1, 32'(TUNE_ADDR), v, q, e);
         apb(1'b0, 32'(TUNE_ADDR), 0, q, e);
         check("TUNE readback", v, q);
      end
      apb(1'b0, 32'h0000_000C, 0, q, e);
      check("unmapped error", 1, e);
      check("unmapped data", 0, q);
      apb(1'b1, 32'h0000_1004, 32'hFFFF_FFFF, q, e);
      apb(1'b0, 32'(TUNE_ADDR), 0, q, e);
      check("TUNE after refused write", v, q);
      apb(1'b1, 32'(TUNE_ADDR), 32'(DOTLVL_RESET) << DOTLVL_LSB, q, e);
      for (int m = 0; m < 10; m++) begin
         page(m, 8'h80, -1, 1'b0);
         check("flat grey mixed", 32'(grey_mixed(m)), 32'(ones > 0 && ones < inner));
      end
      page(TEXT2, 8'hFF, -1, 1'b0);
      check("black all set", inner, ones);
      check("black full pulse", inner, fulls);
      page(SPEC1, 8'h00, -1, 1'b0);
      check("white all clear", 0, ones);
      page(TEXT1, 8'h00, 5 * LW + 8, 1'b0);
      check("lone dot erased", 0, ones);
      page(PHOTO1, 8'h00, 5 * LW + 8, 1'b0);
      check("lone dot kept", 1, 32'(ones > 0));
      page(PHOTO2, 8'h00, -1, 1'b1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("outValid after reset", 0, outValid);
      apb(1'b0, 32'(MODE_ADDR), 0, q, e);
      check("MODE after reset", 32'(DENS_RESET) << DENS_LSB, q);
      complete_run();
   end
endmodule
`default_nettype wire
